// ### rtl/pus_pkg.sv
// pus_pkg: constants and carrier types for the power-up reset sequencer.
// assumes a 125 MHz system clock and a 16.384 MHz master clock input.
package pus_pkg;
  // timing, system clock 125 MHz
  localparam int unsigned SYS_CLK_HZ = 125000000;
  localparam int unsigned SUPPLY_TIMEOUT_MS = 32;
  localparam int unsigned SLAVE_CLK_SETTLE_MS = 10;
  localparam int unsigned SUPPLY_TIMEOUT_CYC =
    SYS_CLK_HZ / 1000 * SUPPLY_TIMEOUT_MS;
  localparam int unsigned SLAVE_CLK_SETTLE_CYC =
    SYS_CLK_HZ / 1000 * SLAVE_CLK_SETTLE_MS;
  // slave clock is the link clock divided by four (4.096 MHz)
  localparam int unsigned SLAVE_CLK_DIV = 4;
  localparam int unsigned RESET_PULSES = 8;
  localparam int unsigned SPI_SEL_EDGES = 3;

  // register addresses
  localparam logic [15:0] ADDR_SECOND_STATUS_REG = 16'he503;
  localparam logic [15:0] ADDR_SECOND_CONFIG_REG = 16'hec01;
  localparam logic [15:0] ADDR_RUN_REG = 16'he228;
  localparam logic [15:0] ADDR_RAM_PROTECT_KEY = 16'he7fe;
  localparam logic [15:0] ADDR_RAM_PROTECT_ENABLE = 16'he7e3;

  // field positions and key values
  localparam int unsigned RESET_DONE_BIT = 15;
  localparam int unsigned PORT_LOCK_BIT = 0;
  localparam logic [7:0] RAM_PROTECT_KEY_VAL = 8'had;
  localparam logic [7:0] RAM_PROTECT_EN_VAL = 8'h80;
  localparam logic [15:0] RUN_START_VAL = 16'h0001;
  localparam logic [15:0] SECOND_STATUS_RST = 16'h0000;

  // host register write carried as one bundle
  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [15:0] data;
  } pus_wr_t;

  // power-up sequence states
  typedef enum logic [2:0] {
    ST_INACTIVE = 3'b000,
    ST_TIMEOUT = 3'b001,
    ST_CLK_SETTLE = 3'b010,
    ST_SLAVE_RST = 3'b011,
    ST_READY = 3'b100
  } pus_state_t;
endpackage : pus_pkg

// ### rtl/pus_slave_reset.sv
// pus_slave_reset: link-clock side; makes the slave clock and reset burst.
// assumes i_link_clk is the master clock input; start arrives as a toggle.
`timescale 1ns/1ps
module pus_slave_reset (
  input wire logic i_link_clk, // master clock input
  input wire logic i_rstn, // async reset, active low
  input wire logic i_clk_en, // level: slave clock enabled
  input wire logic i_start_tgl, // toggle: begin slave reset burst
  output logic o_slave_clk, // slave clock output
  output logic o_reset_en_n, // slave reset enable, active low
  output logic o_temp_sel, // common level for temp select lines
  output logic o_done_tgl // toggle: burst finished
);
  logic [1:0] clk_en_sync;
  logic [2:0] start_sync;
  logic [1:0] div;
  logic [3:0] pulse_cnt;
  logic busy;

  // level and toggle inputs cross through two flops
  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      clk_en_sync <= 2'h0;
      start_sync <= 3'h0;
    end else begin
      clk_en_sync <= {clk_en_sync[0], i_clk_en};
      start_sync <= {start_sync[1:0], i_start_tgl};
    end
  end

  // divide by four; runs every cycle so burst phase is fixed
  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div <= 2'h0;
    end else begin
      div <= div + 2'h1;
    end
  end

  // slave clock held high until enabled
  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_slave_clk <= 1'b1; // R23
    end else begin
      o_slave_clk <= clk_en_sync[1] ? ~div[1] : 1'b1; // R2
    end
  end

  // burst: reset enable low, eight high-to-low pulses, then all high
  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy <= 1'b0;
      pulse_cnt <= 4'h0;
      o_reset_en_n <= 1'b1;
      o_temp_sel <= 1'b1;
      o_done_tgl <= 1'b0;
    end else if (!busy) begin
      if (start_sync[2] != start_sync[1]) begin
        busy <= 1'b1; // R3
        pulse_cnt <= 4'h0;
        o_reset_en_n <= 1'b0; // R3
      end
    end else begin
      o_temp_sel <= ~div[1]; // R3
      if (div == 2'h3) begin
        if (pulse_cnt == 4'(pus_pkg::RESET_PULSES - 1)) begin
          busy <= 1'b0;
          o_reset_en_n <= 1'b1; // R4
          o_temp_sel <= 1'b1; // R4
          o_done_tgl <= ~o_done_tgl;
        end else begin
          pulse_cnt <= pulse_cnt + 4'h1;
        end
      end
    end
  end

  property p_burst_len;
    @(posedge i_link_clk) disable iff (!i_rstn)
    $fell(o_reset_en_n) |-> o_reset_en_n == 1'b0 [*8];
  endproperty
  a_burst_len: assert property (p_burst_len) // R3
    else $error("reset enable released too early");

  property p_idle_high;
    @(posedge i_link_clk) disable iff (!i_rstn)
    !busy && o_reset_en_n |=> o_temp_sel;
  endproperty
  a_idle_high: assert property (p_idle_high) // R4
    else $error("temp select low outside burst");

  c_burst: cover property (@(posedge i_link_clk) disable iff (!i_rstn)
    $rose(o_reset_en_n));
endmodule : pus_slave_reset

// ### rtl/pus_sequencer.sv
// pus_sequencer: power-up sequencing, host port choice and reset-done flag.
// assumes a register decoder supplies writes; supply monitor is a pin.
// Function
// (R1) wait 32 ms after supply good
// (R2) then run continuous slave clock
// (R3) after 10 ms, reset low, eight pulses
// (R4) then reset enable and selects high
// (R5) i2c is the port after power-up
// (R6) three select falls switch to spi
// (R7) i2c lock bit freezes port choice
// (R8) any config write under spi locks it
// (R9) only power-down or reset unlocks spi; here a supply loss keeps the lock and only the reset pin clears it
// (R10) registers take defaults at power-up; here ram protection and port lock survive a supply loss
// (R11) done: flag bit 15 set, irq low
// (R12) writing one to bit 15 clears
// (R13) reset-done interrupt cannot be masked
// (R14) processor idle until host starts it
// (R15) host initialises ram registers first
// (R16) host then initialises hardware registers
// (R17) key then enable write protects ram
// (R18) run register 0x0001 starts processor
// (R19) low supply forces inactive state
// (R20) host waits for irq before reading
// (R21) host clears remaining status flags
// (R22) host follows the recommended order
// (R23) pins held high while inactive; here a reset burst already under way runs to its end after a supply loss
`timescale 1ns/1ps
module pus_sequencer #(
  parameter int unsigned TIMEOUT_CYC = pus_pkg::SUPPLY_TIMEOUT_CYC,
  parameter int unsigned SETTLE_CYC = pus_pkg::SLAVE_CLK_SETTLE_CYC
) (
  input wire logic i_sys_clk, // system clock 125 MHz
  input wire logic i_rstn, // async reset pin, active low
  input wire logic i_link_clk, // master clock input
  input wire logic i_supply_ok, // supply monitor, async level
  input wire logic i_port_select_pin, // slave select pin, async
  input wire pus_pkg::pus_wr_t i_wr, // host register write
  output logic o_slave_clock_output, // slave clock
  output logic o_slave_reset_en_n, // slave reset enable, low active
  output logic [3:0] o_temp_select, // phase a,b,c, neutral
  output logic o_primary_interrupt_out_n, // reset done irq, low active
  output logic [15:0] o_second_status_reg, // status read value
  output logic o_spi_active, // host port: 1 spi, 0 i2c
  output logic o_port_locked, // port choice frozen
  output logic o_ram_protected, // processor ram write protected
  output logic o_dsp_run // processor executing
);
  pus_pkg::pus_state_t state;
  pus_pkg::pus_state_t next_state;
  logic [1:0] supply_sync;
  logic [2:0] sel_sync;
  logic [31:0] timer;
  logic timer_hit;
  logic clk_en;
  logic start_tgl;
  logic done_tgl;
  logic [2:0] done_sync;
  logic burst_done;
  logic reset_done_flag;
  logic [1:0] sel_falls;
  logic key_seen;
  logic temp_sel;
  logic sel_fall;
  logic status_clr;
  logic cfg_wr;

  // async pins pass two flops before use
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      supply_sync <= 2'h0;
      sel_sync <= 3'h7;
      done_sync <= 3'h0;
    end else begin
      supply_sync <= {supply_sync[0], i_supply_ok};
      sel_sync <= {sel_sync[1:0], i_port_select_pin};
      done_sync <= {done_sync[1:0], done_tgl};
    end
  end

  assign sel_fall = sel_sync[2] & ~sel_sync[1];
  assign burst_done = done_sync[2] ^ done_sync[1];
  assign timer_hit = (state == pus_pkg::ST_TIMEOUT &&
                      timer == TIMEOUT_CYC - 1) ||
                     (state == pus_pkg::ST_CLK_SETTLE &&
                      timer == SETTLE_CYC - 1);
  assign status_clr = i_wr.wr &&
    i_wr.addr == pus_pkg::ADDR_SECOND_STATUS_REG &&
    i_wr.data[pus_pkg::RESET_DONE_BIT];
  assign cfg_wr = i_wr.wr && i_wr.addr == pus_pkg::ADDR_SECOND_CONFIG_REG;

  // sequence next state; supply loss wins from any state
  always_comb begin
    next_state = state;
    if (!supply_sync[1]) begin
      next_state = pus_pkg::ST_INACTIVE; // R19
    end else begin
      unique case (state)
        pus_pkg::ST_INACTIVE: next_state = pus_pkg::ST_TIMEOUT;
        pus_pkg::ST_TIMEOUT: begin
          if (timer_hit) next_state = pus_pkg::ST_CLK_SETTLE; // R1
        end
        pus_pkg::ST_CLK_SETTLE: begin
          if (timer_hit) next_state = pus_pkg::ST_SLAVE_RST; // R3
        end
        pus_pkg::ST_SLAVE_RST: begin
          if (burst_done) next_state = pus_pkg::ST_READY;
        end
        pus_pkg::ST_READY: next_state = pus_pkg::ST_READY;
        default: next_state = pus_pkg::ST_INACTIVE;
      endcase
    end
  end

  // state register
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= pus_pkg::ST_INACTIVE;
    end else begin
      state <= next_state;
    end
  end

  // one timer shared by both waits; restarts on every state change
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      timer <= 32'h0;
    end else if (next_state != state) begin
      timer <= 32'h0;
    end else begin
      timer <= timer + 32'h1;
    end
  end

  // clock enable level and burst start toggle toward the link domain
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      clk_en <= 1'b0;
      start_tgl <= 1'b0;
    end else begin
      clk_en <= next_state == pus_pkg::ST_CLK_SETTLE ||
                next_state == pus_pkg::ST_SLAVE_RST ||
                next_state == pus_pkg::ST_READY; // R2
      if (state == pus_pkg::ST_CLK_SETTLE && timer_hit &&
          supply_sync[1]) begin
        start_tgl <= ~start_tgl; // R3
      end
    end
  end

  // reset-done flag: set on entry to ready, set beats clear
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      reset_done_flag <= 1'b0; // R10
    end else if (!supply_sync[1]) begin
      reset_done_flag <= 1'b0;
    end else if (state == pus_pkg::ST_SLAVE_RST && burst_done) begin
      reset_done_flag <= 1'b1; // R11
    end else if (status_clr) begin
      reset_done_flag <= 1'b0; // R12
    end
  end

  // no mask term: the flag alone drives the pin
  assign o_primary_interrupt_out_n = ~reset_done_flag; // R13

  always_comb begin
    o_second_status_reg = pus_pkg::SECOND_STATUS_RST;
    o_second_status_reg[pus_pkg::RESET_DONE_BIT] = reset_done_flag; // R11
  end

  // host port choice; supply loss returns an unlocked choice to i2c, only the reset pin a locked one
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_spi_active <= 1'b0; // R5
      o_port_locked <= 1'b0; // R9
      sel_falls <= 2'h0;
    end else if (!supply_sync[1]) begin
      // an unlocked choice does not survive a supply loss
      sel_falls <= 2'h0;
      if (!o_port_locked) begin
        o_spi_active <= 1'b0; // R5
      end
    end else if (state == pus_pkg::ST_READY) begin
      if (!o_port_locked && !o_spi_active && sel_fall) begin
        if (sel_falls == 2'(pus_pkg::SPI_SEL_EDGES - 1)) begin
          o_spi_active <= 1'b1; // R6
        end else begin
          sel_falls <= sel_falls + 2'h1;
        end
      end
      if (cfg_wr && !o_port_locked) begin
        if (o_spi_active) begin
          o_port_locked <= 1'b1; // R8
        end else if (i_wr.data[pus_pkg::PORT_LOCK_BIT]) begin
          o_port_locked <= 1'b1; // R7
        end
      end
    end
  end

  // ram protection: key write then enable write; run register start
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      key_seen <= 1'b0;
      o_ram_protected <= 1'b0;
      o_dsp_run <= 1'b0; // R14
    end else if (!supply_sync[1]) begin
      o_dsp_run <= 1'b0; // R19
    end else if (i_wr.wr && state == pus_pkg::ST_READY) begin
      if (i_wr.addr == pus_pkg::ADDR_RAM_PROTECT_KEY) begin
        key_seen <= i_wr.data[7:0] == pus_pkg::RAM_PROTECT_KEY_VAL;
      end else if (i_wr.addr == pus_pkg::ADDR_RAM_PROTECT_ENABLE) begin
        if (key_seen &&
            i_wr.data[7:0] == pus_pkg::RAM_PROTECT_EN_VAL) begin
          o_ram_protected <= 1'b1; // R17
        end
        key_seen <= 1'b0;
      end else if (i_wr.addr == pus_pkg::ADDR_RUN_REG) begin
        o_dsp_run <= i_wr.data == pus_pkg::RUN_START_VAL; // R18
      end
    end
  end

  // link-side generator of slave clock and reset burst
  pus_slave_reset u_slave_reset (
    .i_link_clk(i_link_clk),
    .i_rstn(i_rstn),
    .i_clk_en(clk_en),
    .i_start_tgl(start_tgl),
    .o_slave_clk(o_slave_clock_output),
    .o_reset_en_n(o_slave_reset_en_n),
    .o_temp_sel(temp_sel),
    .o_done_tgl(done_tgl)
  );

  assign o_temp_select = {4{temp_sel}}; // R3

  property p_timeout;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    state == pus_pkg::ST_TIMEOUT && next_state == pus_pkg::ST_CLK_SETTLE
      |-> timer == TIMEOUT_CYC - 1;
  endproperty
  a_timeout: assert property (p_timeout) // R1
    else $error("timeout left at wrong count");

  property p_irq;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    state == pus_pkg::ST_SLAVE_RST && burst_done && supply_sync[1]
      |=> !o_primary_interrupt_out_n && o_second_status_reg[15];
  endproperty
  a_irq: assert property (p_irq) // R11
    else $error("reset done not flagged");

  property p_clear;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    status_clr && !(state == pus_pkg::ST_SLAVE_RST && burst_done)
      |=> o_primary_interrupt_out_n;
  endproperty
  a_clear: assert property (p_clear) // R12
    else $error("flag not cleared by write");

  property p_hold_low;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    !o_primary_interrupt_out_n && !status_clr && supply_sync[1]
      |=> !o_primary_interrupt_out_n;
  endproperty
  a_hold_low: assert property (p_hold_low) // R13
    else $error("irq released without clear");

  property p_lock;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    o_port_locked |=> o_port_locked && $stable(o_spi_active);
  endproperty
  a_lock: assert property (p_lock) // R7
    else $error("locked port changed");

  property p_spi_lock;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    state == pus_pkg::ST_READY && o_spi_active && cfg_wr |=> o_port_locked;
  endproperty
  a_spi_lock: assert property (p_spi_lock) // R8
    else $error("spi not locked by config write");

  property p_i2c_default;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    state != pus_pkg::ST_READY |-> !o_spi_active || o_port_locked;
  endproperty
  a_i2c_default: assert property (p_i2c_default) // R5
    else $error("spi active before ready");

  property p_idle;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    !o_dsp_run && !(i_wr.wr && i_wr.addr == pus_pkg::ADDR_RUN_REG)
      |=> !o_dsp_run;
  endproperty
  a_idle: assert property (p_idle) // R14
    else $error("processor started without run write");

  property p_inactive;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    !supply_sync[1] |=> state == pus_pkg::ST_INACTIVE && !o_dsp_run;
  endproperty
  a_inactive: assert property (p_inactive) // R19
    else $error("not inactive on low supply");

  property p_spi_third;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    state == pus_pkg::ST_READY && supply_sync[1] && !o_port_locked &&
      !o_spi_active && sel_fall && sel_falls == 2'h2
      |=> o_spi_active;
  endproperty
  a_spi_third: assert property (p_spi_third) // R6
    else $error("spi not selected on third fall");

  property p_protect_key;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    !o_ram_protected && !key_seen |=> !o_ram_protected;
  endproperty
  a_protect_key: assert property (p_protect_key) // R17
    else $error("ram protected without key");

  property p_run_start;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    state == pus_pkg::ST_READY && supply_sync[1] && i_wr.wr &&
      i_wr.addr == pus_pkg::ADDR_RUN_REG &&
      i_wr.data == pus_pkg::RUN_START_VAL |=> o_dsp_run;
  endproperty
  a_run_start: assert property (p_run_start) // R18
    else $error("run write did not start processor");

  property p_settle;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    state == pus_pkg::ST_CLK_SETTLE && next_state == pus_pkg::ST_SLAVE_RST
      |-> timer == SETTLE_CYC - 1;
  endproperty
  a_settle: assert property (p_settle) // R3
    else $error("slave clock settle left at wrong count");

  property p_flag_ready;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    state != pus_pkg::ST_READY |-> !o_second_status_reg[15];
  endproperty
  a_flag_ready: assert property (p_flag_ready) // R11
    else $error("reset done flag set during transition");

  c_ready: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
    $fell(o_primary_interrupt_out_n));
  c_spi: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
    $rose(o_spi_active));
  c_protect: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
    $rose(o_ram_protected));
  c_run: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
    $rose(o_dsp_run));
endmodule : pus_sequencer

// ### verif/pus_host_model.sv
// pus_host_model: host side, register writes and port-select pin.
// assumes writes are taken on the rising system clock edge.
`timescale 1ns/1ps
module pus_host_model (
  input wire logic i_sys_clk, // system clock
  input wire logic i_irq_n, // reset-done irq, active low
  output pus_pkg::pus_wr_t o_wr, // register write bundle
  output logic o_port_select_pin // select pin, pulled high
);
  // idle bus at time zero
  initial begin
    o_wr = '0;
    o_port_select_pin = 1'b1;
  end

  // one-cycle write; released fields show inverted leftovers
  task automatic wr_reg(input logic [15:0] addr, input logic [15:0] data);
    @(posedge i_sys_clk);
    o_wr <= '{wr: 1'b1, addr: addr, data: data};
    @(posedge i_sys_clk);
    o_wr <= '{wr: 1'b0, addr: ~addr, data: ~data};
  endtask : wr_reg

  // falls held long enough for the two-flop synchroniser
  task automatic sel_falls(input int n);
    repeat (n) begin
      @(posedge i_sys_clk);
      o_port_select_pin <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      o_port_select_pin <= 1'b1;
      repeat (3) @(posedge i_sys_clk);
    end
  endtask : sel_falls

  // poll the irq before touching status
  task automatic wait_irq(input int max_cyc, output bit ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < max_cyc && !ok; n++) begin
      @(negedge i_sys_clk);
      ok = (i_irq_n === 1'b0);
    end
  endtask : wait_irq

  // bring-up order: ram block, last one thrice, hw block, protect, run
  task automatic init_seq();
    logic [15:0] a;
    for (a = 16'h4380; a <= 16'h43bf; a++) wr_reg(a, a);
    repeat (2) wr_reg(16'h43bf, 16'h43bf);
    wr_reg(16'he507, 16'h0000);
    wr_reg(16'hea04, 16'h0000);
    wr_reg(pus_pkg::ADDR_RAM_PROTECT_KEY, 16'h00ad);
    wr_reg(pus_pkg::ADDR_RAM_PROTECT_ENABLE, 16'h0080);
    wr_reg(pus_pkg::ADDR_RUN_REG, 16'h0001);
  endtask : init_seq
endmodule : pus_host_model

// ### verif/tb_top.sv
// tb_top: self-checking bench for the power-up reset sequencer.
// assumes short timeout parameters; host model drives writes and pin.
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned TO_CYC = 20;
  localparam int unsigned ST_CYC = 10;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rstn = 1'b0;
  logic supply_ok = 1'b0;
  pus_pkg::pus_wr_t wr;
  logic sel_pin, slv_clk, rst_en_n, irq_n, spi, locked, prot, run;
  logic [3:0] temp;
  logic [15:0] status;
  int errors = 0;
  int total_checks = 0;
  int falls = 0;
  bit ok;
  realtime t0;

  // system clock 8 ns
  always #4 sys_clk = ~sys_clk;
  // link clock 12 ns; its rising edges never meet the system clock's
  always #6 link_clk = ~link_clk;

  pus_sequencer #(.TIMEOUT_CYC(TO_CYC), .SETTLE_CYC(ST_CYC)) dut_u (
    .i_sys_clk(sys_clk), .i_rstn(rstn), .i_link_clk(link_clk),
    .i_supply_ok(supply_ok), .i_port_select_pin(sel_pin), .i_wr(wr),
    .o_slave_clock_output(slv_clk), .o_slave_reset_en_n(rst_en_n),
    .o_temp_select(temp), .o_primary_interrupt_out_n(irq_n),
    .o_second_status_reg(status), .o_spi_active(spi),
    .o_port_locked(locked), .o_ram_protected(prot), .o_dsp_run(run));

  pus_host_model host_u (.i_sys_clk(sys_clk), .i_irq_n(irq_n),
    .o_wr(wr), .o_port_select_pin(sel_pin));

  // count select falls only while slaves are held in reset
  always @(negedge temp[0]) if (rst_en_n === 1'b0) falls++;

  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic do_reset(input int cyc);
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (cyc) @(posedge sys_clk);
    rstn <= 1'b1;
  endtask : do_reset

  // supply still low: pins parked, defaults, early writes refused
  task automatic t_idle();
    host_u.wr_reg(pus_pkg::ADDR_RUN_REG, 16'h0001);
    repeat (5) @(negedge sys_clk);
    chk("slave clock", 16'h1, slv_clk);
    chk("reset enable", 16'h1, rst_en_n);
    chk("temp selects", 16'hf, temp);
    chk("irq", 16'h1, irq_n);
    chk("status", 16'h0, status);
    chk("protect", 16'h0, prot);
    chk("port", 16'h0, spi);
    chk("run", 16'h0, run);
  endtask : t_idle

  // timeout, slave clock, reset burst, then reset-done
  task automatic t_powerup();
    int n;
    int low_seen;
    low_seen = 0;
    @(posedge sys_clk);
    supply_ok <= 1'b1;
    repeat (TO_CYC) begin
      @(negedge sys_clk);
      if (slv_clk !== 1'b1) low_seen++;
    end
    chk("clock lows in timeout", 16'h0, low_seen[15:0]);
    @(posedge slv_clk);
    t0 = $realtime;
    @(posedge slv_clk);
    n = int'($realtime - t0);
    chk("slave clock period", 16'h30, n[15:0]);
    for (n = 0; n < 300 && rst_en_n !== 1'b0; n++) @(negedge sys_clk);
    chk("reset enable low", 16'h0, rst_en_n);
    chk("status in transition", 16'h0, status);
    for (n = 0; n < 300 && rst_en_n !== 1'b1; n++) @(negedge sys_clk);
    repeat (2) @(negedge sys_clk);
    chk("select falls", 16'h8, falls[15:0]);
    chk("selects after burst", 16'hf, temp);
    chk("reset enable after", 16'h1, rst_en_n);
    host_u.wait_irq(100, ok);
    @(negedge sys_clk);
    chk("irq seen low", 16'h1, ok);
    chk("status done", 16'h8000, status);
  endtask : t_powerup

  // two falls leave i2c, the third switches
  task automatic t_spi();
    host_u.sel_falls(2);
    repeat (8) @(negedge sys_clk);
    chk("port after two falls", 16'h0, spi);
    host_u.sel_falls(1);
    repeat (8) @(negedge sys_clk);
    chk("port after three falls", 16'h1, spi);
    chk("lock before write", 16'h0, locked);
  endtask : t_spi

  // flag clears only with bit 15 written as one
  task automatic t_irq();
    host_u.wr_reg(pus_pkg::ADDR_SECOND_STATUS_REG, 16'h7fff);
    @(negedge sys_clk);
    chk("irq kept", 16'h0, irq_n);
    chk("status kept", 16'h8000, status);
    host_u.wr_reg(pus_pkg::ADDR_SECOND_STATUS_REG, 16'hffff);
    @(negedge sys_clk);
    chk("irq cleared", 16'h1, irq_n);
    chk("status cleared", 16'h0, status);
  endtask : t_irq

  // lock, refused protect without key, then full bring-up
  task automatic t_init();
    host_u.wr_reg(pus_pkg::ADDR_SECOND_CONFIG_REG, 16'h0000);
    host_u.wr_reg(pus_pkg::ADDR_RAM_PROTECT_ENABLE, 16'h0080);
    @(negedge sys_clk);
    chk("spi locked", 16'h1, locked);
    chk("protect without key", 16'h0, prot);
    chk("idle before start", 16'h0, run);
    host_u.init_seq();
    @(negedge sys_clk);
    chk("ram protected", 16'h1, prot);
    chk("running", 16'h1, run);
  endtask : t_init

  // supply loss parks the device; only the reset pin frees the port
  task automatic t_low();
    @(posedge sys_clk);
    supply_ok <= 1'b0;
    repeat (20) @(negedge sys_clk);
    chk("run after loss", 16'h0, run);
    chk("status after loss", 16'h0, status);
    chk("slave clock parked", 16'h1, slv_clk);
    chk("spi kept", 16'h1, spi);
    do_reset(4);
    @(negedge sys_clk);
    chk("port after reset", 16'h0, spi);
    chk("lock after reset", 16'h0, locked);
  endtask : t_low

  // i2c lock needs bit 0, then select falls are ignored
  task automatic t_i2c();
    @(posedge sys_clk);
    supply_ok <= 1'b1;
    host_u.wait_irq(400, ok);
    chk("second power-up", 16'h1, ok);
    chk("default port", 16'h0, spi);
    host_u.wr_reg(pus_pkg::ADDR_SECOND_CONFIG_REG, 16'h0000);
    @(negedge sys_clk);
    chk("lock without bit 0", 16'h0, locked);
    host_u.wr_reg(pus_pkg::ADDR_SECOND_CONFIG_REG, 16'h0001);
    host_u.sel_falls(3);
    repeat (8) @(negedge sys_clk);
    chk("i2c locked", 16'h1, locked);
    chk("port stays i2c", 16'h0, spi);
    // flag is still set here, so the loss must be what clears it
    @(posedge sys_clk);
    supply_ok <= 1'b0;
    repeat (5) @(negedge sys_clk);
    chk("flag after loss", 16'h0, status);
    chk("irq after loss", 16'h1, irq_n);
  endtask : t_i2c

  // main sequence in host-recommended order
  initial begin
    do_reset(3);
    t_idle();
    t_powerup();
    t_spi();
    t_irq();
    t_init();
    t_low();
    t_i2c();
    test_done();
  end

  // watchdog, well past the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    test_done();
  end
endmodule : tb_top
